// ===== cbbae_cfg.svh
// constants for the bit, branch and add execution unit
`ifndef CBBAE_CFG_SVH
`define CBBAE_CFG_SVH

// opcodes, fixed codes
`define CBBAE_OP_ANL_C_BIT  8'h82
`define CBBAE_OP_ANL_C_NBIT 8'hB0
`define CBBAE_OP_ORL_C_BIT  8'h7A
`define CBBAE_OP_ORL_C_NBIT 8'hA0
`define CBBAE_OP_MOV_C_BIT  8'hA2
`define CBBAE_OP_MOV_BIT_C  8'h93
`define CBBAE_OP_JC         8'h40
`define CBBAE_OP_JNC        8'h50
`define CBBAE_OP_JB         8'h20
`define CBBAE_OP_JNB        8'h30
`define CBBAE_OP_JBC        8'h10
`define CBBAE_OP_LCALL      8'h03
`define CBBAE_OP_RET        8'h22
`define CBBAE_OP_RETI       8'h33
`define CBBAE_OP_LJMP       8'h02
`define CBBAE_OP_SJMP       8'h80
`define CBBAE_OP_JMP_IND    8'h73
`define CBBAE_OP_JZ         8'h60
`define CBBAE_OP_JNZ        8'h70
`define CBBAE_OP_CJNE_ADIR  8'hB5
`define CBBAE_OP_CJNE_AIMM  8'hB4
`define CBBAE_OP_DJNZ_DIR   8'hD5
`define CBBAE_OP_ADD_DIR    8'h25
`define CBBAE_OP_ADD_IMM    8'h24
`define CBBAE_OP_ADDC_DIR   8'h35
`define CBBAE_OP_ADDC_IMM   8'h34
// opcode patterns
`define CBBAE_PAT_ADD_REG   8'b0010_1???
`define CBBAE_PAT_ADD_IND   8'b0010_011?
`define CBBAE_PAT_ADDC_REG  8'b0011_1???
`define CBBAE_PAT_ADDC_IND  8'b0011_011?
`define CBBAE_PAT_CJNE_IND  8'b1011_011?
`define CBBAE_PAT_CJNE_REG  8'b1011_1???
`define CBBAE_PAT_DJNZ_REG  8'b1101_1???
// low five bits of the page-address forms
`define CBBAE_ACALL_LOW     5'b10010
`define CBBAE_AJMP_LOW      5'b00001

// execution clock counts
`define CBBAE_CYC_ADD       3'h1
`define CBBAE_CYC_3         3'h3
`define CBBAE_CYC_4         3'h4
`define CBBAE_CYC_5         3'h5
`define CBBAE_CYC_CALL      3'h6
// push phases of a call, as clocks left
`define CBBAE_PUSH_LO_REM   3'h3
`define CBBAE_PUSH_HI_REM   3'h2

`endif

// ===== cbbae_exec.sv
// execution unit for bit, branch and add instructions
`timescale 1ns/1ns
`include "cbbae_cfg.svh"

// What this block does
// - carry and/or with bit: 3 clocks
// - bit into carry 3, carry into bit 4
// - jump on carry: 3 clocks always
// - bit test jumps 4, jump-and-clear 5
// - jumps: 3, 4, 3, 3 clocks
// - accumulator zero jumps take 3 clocks
// - compare jumps: 5, 4, 5 clocks
// - decrement jumps: register 4, direct 5
// - call pushes low then high byte
// - call target keeps upper five pc bits
// - call opcode: a10-a8 then 10010
// - absolute jump stays in 2K block
// - add sets carry and half carry
// - overflow is carry6 xor carry7
// - add with carry includes carry flag
// - add opcode decoding per form
// - add with carry opcode decoding
// - all add forms take one clock
module cbbae_exec
    import cbbae_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         issue_valid,
    input  wire cbbae_instr_t instr,
    input  wire cbbae_arch_t  arch_in,
    input  wire logic [7:0]   operand,
    input  wire logic [7:0]   operand_addr,
    input  wire logic         bit_in,
    input  wire logic [15:0]  ret_addr_in,
    output logic              ready,
    output logic              done,
    output logic              unknown_op,
    output cbbae_arch_t       arch_out,
    output logic              ram_we,
    output logic [7:0]        ram_addr,
    output logic [7:0]        ram_wdata,
    output logic              bit_we,
    output logic [7:0]        bit_addr,
    output logic              bit_wdata
);

    cbbae_state_t st;
    cbbae_state_t next_st;
    logic         take;
    logic [15:0]  pc_seq;
    logic [7:0]   src;
    logic         cin;
    logic [4:0]   sum4;
    logic [7:0]   sum7;
    logic [8:0]   sum8;
    logic [7:0]   cmp_l;
    logic [7:0]   cmp_r;
    logic [7:0]   dec_v;

    function automatic logic page_call(input logic [7:0] op);
        page_call = (op[4:0] == `CBBAE_ACALL_LOW);
    endfunction

    function automatic logic page_jump(input logic [7:0] op);
        page_jump = (op[4:0] == `CBBAE_AJMP_LOW);
    endfunction

    function automatic logic [2:0] cyc_of(input logic [7:0] op);
        cyc_of = `CBBAE_CYC_ADD;
        if (page_call(op))
            cyc_of = `CBBAE_CYC_CALL;
        else if (page_jump(op))
            cyc_of = `CBBAE_CYC_3;
        else
        begin
            casez (op)
                `CBBAE_OP_ANL_C_BIT, `CBBAE_OP_ANL_C_NBIT,
                `CBBAE_OP_ORL_C_BIT, `CBBAE_OP_ORL_C_NBIT,
                `CBBAE_OP_MOV_C_BIT, `CBBAE_OP_JC, `CBBAE_OP_JNC,
                `CBBAE_OP_SJMP, `CBBAE_OP_JMP_IND,
                `CBBAE_OP_JZ, `CBBAE_OP_JNZ:
                    cyc_of = `CBBAE_CYC_3;
                `CBBAE_OP_MOV_BIT_C, `CBBAE_OP_JB, `CBBAE_OP_JNB,
                `CBBAE_OP_RET, `CBBAE_OP_RETI, `CBBAE_OP_LJMP,
                `CBBAE_OP_CJNE_AIMM, `CBBAE_PAT_CJNE_REG,
                `CBBAE_PAT_DJNZ_REG:
                    cyc_of = `CBBAE_CYC_4;
                `CBBAE_OP_JBC, `CBBAE_OP_CJNE_ADIR, `CBBAE_PAT_CJNE_IND,
                `CBBAE_OP_DJNZ_DIR:
                    cyc_of = `CBBAE_CYC_5;
                `CBBAE_OP_LCALL:
                    cyc_of = `CBBAE_CYC_CALL;
                default:
                    cyc_of = `CBBAE_CYC_ADD;
            endcase
        end
    endfunction

    function automatic logic [15:0] len_of(input logic [7:0] op);
        len_of = 16'h0001;
        if (page_call(op) || page_jump(op))
            len_of = 16'h0002;
        else
        begin
            casez (op)
                `CBBAE_OP_JB, `CBBAE_OP_JNB, `CBBAE_OP_JBC,
                `CBBAE_OP_LCALL, `CBBAE_OP_LJMP,
                `CBBAE_OP_CJNE_ADIR, `CBBAE_OP_CJNE_AIMM,
                `CBBAE_PAT_CJNE_IND, `CBBAE_PAT_CJNE_REG,
                `CBBAE_OP_DJNZ_DIR:
                    len_of = 16'h0003;
                `CBBAE_OP_ANL_C_BIT, `CBBAE_OP_ANL_C_NBIT,
                `CBBAE_OP_ORL_C_BIT, `CBBAE_OP_ORL_C_NBIT,
                `CBBAE_OP_MOV_C_BIT, `CBBAE_OP_MOV_BIT_C,
                `CBBAE_OP_JC, `CBBAE_OP_JNC, `CBBAE_OP_SJMP,
                `CBBAE_OP_JZ, `CBBAE_OP_JNZ, `CBBAE_PAT_DJNZ_REG,
                `CBBAE_OP_ADD_DIR, `CBBAE_OP_ADD_IMM,
                `CBBAE_OP_ADDC_DIR, `CBBAE_OP_ADDC_IMM:
                    len_of = 16'h0002;
                default:
                    len_of = 16'h0001;
            endcase
        end
    endfunction

    function automatic logic [15:0] rel(input logic [15:0] base,
                                        input logic [7:0]  off);
        rel = base + {{8{off[7]}}, off};
    endfunction

    // next instruction may be taken in the done cycle
    assign ready = (st.rem <= 3'h1);
    assign take  = issue_valid && ready;
    assign done  = (st.rem == 3'h1);

    always_comb
    begin
        next_st = st;
        pc_seq  = arch_in.pc + len_of(instr.op);
        src     = operand;
        cin     = 1'b0;
        cmp_l   = operand;
        cmp_r   = instr.b1;
        dec_v   = operand - 8'h01;
        if ((instr.op == `CBBAE_OP_ADD_IMM) ||
            (instr.op == `CBBAE_OP_ADDC_IMM))
            src = instr.b1;
        if (instr.op[4])
            cin = arch_in.cy;
        sum4 = {1'b0, arch_in.acc[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
        sum7 = {1'b0, arch_in.acc[6:0]} + {1'b0, src[6:0]} + {7'h00, cin};
        sum8 = {1'b0, arch_in.acc} + {1'b0, src} + {8'h00, cin};
        if (instr.op == `CBBAE_OP_CJNE_ADIR)
        begin
            cmp_l = arch_in.acc;
            cmp_r = operand;
        end
        else if (instr.op == `CBBAE_OP_CJNE_AIMM)
            cmp_l = arch_in.acc;
        if (st.rem != 3'h0)
            next_st.rem = st.rem - 3'h1;
        if (take)
        begin
            next_st.rem     = cyc_of(instr.op);
            next_st.arch    = arch_in;
            next_st.arch.pc = pc_seq;
            next_st.unknown = 1'b0;
            next_st.call    = 1'b0;
            next_st.sp_base = arch_in.stack_pointer;
            next_st.ret     = pc_seq;
            next_st.bit_wr  = 1'b0;
            next_st.bit_val = 1'b0;
            next_st.bit_addr  = instr.b1;
            next_st.byte_wr   = 1'b0;
            next_st.byte_val  = dec_v;
            next_st.byte_addr = operand_addr;
            if (page_call(instr.op) || page_jump(instr.op))
            begin
                next_st.arch.pc = {pc_seq[15:11], instr.op[7:5], instr.b1};
                if (page_call(instr.op))
                begin
                    next_st.call = 1'b1;
                    next_st.arch.stack_pointer =
                        arch_in.stack_pointer + 8'h02;
                end
            end
            else
            begin
                casez (instr.op)
                    `CBBAE_PAT_ADD_REG, `CBBAE_PAT_ADD_IND,
                    `CBBAE_OP_ADD_DIR, `CBBAE_OP_ADD_IMM,
                    `CBBAE_PAT_ADDC_REG, `CBBAE_PAT_ADDC_IND,
                    `CBBAE_OP_ADDC_DIR, `CBBAE_OP_ADDC_IMM:
                    begin
                        next_st.arch.acc = sum8[7:0];
                        next_st.arch.cy  = sum8[8];
                        next_st.arch.half_carry_flag = sum4[4];
                        next_st.arch.signed_overflow_flag = sum7[7] ^ sum8[8];
                    end
                    `CBBAE_OP_ANL_C_BIT:
                        next_st.arch.cy = arch_in.cy & bit_in;
                    `CBBAE_OP_ANL_C_NBIT:
                        next_st.arch.cy = arch_in.cy & ~bit_in;
                    `CBBAE_OP_ORL_C_BIT:
                        next_st.arch.cy = arch_in.cy | bit_in;
                    `CBBAE_OP_ORL_C_NBIT:
                        next_st.arch.cy = arch_in.cy | ~bit_in;
                    `CBBAE_OP_MOV_C_BIT:
                        next_st.arch.cy = bit_in;
                    `CBBAE_OP_MOV_BIT_C:
                    begin
                        next_st.bit_wr  = 1'b1;
                        next_st.bit_val = arch_in.cy;
                    end
                    `CBBAE_OP_JC:
                        if (arch_in.cy)
                            next_st.arch.pc = rel(pc_seq, instr.b1);
                    `CBBAE_OP_JNC:
                        if (!arch_in.cy)
                            next_st.arch.pc = rel(pc_seq, instr.b1);
                    `CBBAE_OP_JB:
                        if (bit_in)
                            next_st.arch.pc = rel(pc_seq, instr.b2);
                    `CBBAE_OP_JNB:
                        if (!bit_in)
                            next_st.arch.pc = rel(pc_seq, instr.b2);
                    `CBBAE_OP_JBC:
                        if (bit_in)
                        begin
                            next_st.arch.pc = rel(pc_seq, instr.b2);
                            next_st.bit_wr  = 1'b1;
                        end
                    `CBBAE_OP_LCALL:
                    begin
                        next_st.call    = 1'b1;
                        next_st.arch.pc = {instr.b1, instr.b2};
                        next_st.arch.stack_pointer =
                            arch_in.stack_pointer + 8'h02;
                    end
                    `CBBAE_OP_RET, `CBBAE_OP_RETI:
                    begin
                        // stack read is done outside; value comes in
                        next_st.arch.pc = ret_addr_in;
                        next_st.arch.stack_pointer =
                            arch_in.stack_pointer - 8'h02;
                    end
                    `CBBAE_OP_LJMP:
                        next_st.arch.pc = {instr.b1, instr.b2};
                    `CBBAE_OP_SJMP:
                        next_st.arch.pc = rel(pc_seq, instr.b1);
                    `CBBAE_OP_JMP_IND:
                        next_st.arch.pc = arch_in.data_pointer +
                                          {8'h00, arch_in.acc};
                    `CBBAE_OP_JZ:
                        if (arch_in.acc == 8'h00)
                            next_st.arch.pc = rel(pc_seq, instr.b1);
                    `CBBAE_OP_JNZ:
                        if (arch_in.acc != 8'h00)
                            next_st.arch.pc = rel(pc_seq, instr.b1);
                    `CBBAE_OP_CJNE_ADIR, `CBBAE_OP_CJNE_AIMM,
                    `CBBAE_PAT_CJNE_IND, `CBBAE_PAT_CJNE_REG:
                    begin
                        next_st.arch.cy = (cmp_l < cmp_r);
                        if (cmp_l != cmp_r)
                            next_st.arch.pc = rel(pc_seq, instr.b2);
                    end
                    `CBBAE_PAT_DJNZ_REG, `CBBAE_OP_DJNZ_DIR:
                    begin
                        next_st.byte_wr = 1'b1;
                        if (dec_v != 8'h00)
                            next_st.arch.pc = rel(pc_seq,
                                instr.op[3] ? instr.b1 : instr.b2);
                    end
                    default:
                        next_st.unknown = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            st <= '0;
        else
            st <= next_st;
    end

    // low byte first, then high byte
    assign ram_we = (st.call && ((st.rem == `CBBAE_PUSH_LO_REM) ||
                                 (st.rem == `CBBAE_PUSH_HI_REM))) ||
                    (st.byte_wr && done);
    assign ram_addr  = (st.rem == `CBBAE_PUSH_LO_REM && st.call) ?
                           st.sp_base + 8'h01 :
                       (st.rem == `CBBAE_PUSH_HI_REM && st.call) ?
                           st.sp_base + 8'h02 : st.byte_addr;
    assign ram_wdata = (st.rem == `CBBAE_PUSH_LO_REM && st.call) ?
                           st.ret[7:0] :
                       (st.rem == `CBBAE_PUSH_HI_REM && st.call) ?
                           st.ret[15:8] : st.byte_val;
    assign bit_we     = st.bit_wr && done;
    assign bit_addr   = st.bit_addr;
    assign bit_wdata  = st.bit_val;
    assign arch_out   = st.arch;
    assign unknown_op = st.unknown;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_add_one;
        take && instr.op == `CBBAE_OP_ADD_IMM |-> ##1 done;
    endproperty
    a_add_one: assert property (p_add_one)
        else $error("add did not finish in one clock");

    property p_anl_c;
        take && instr.op == `CBBAE_OP_ANL_C_BIT |-> ##1 !done [*2] ##1 done;
    endproperty
    a_anl_c: assert property (p_anl_c)
        else $error("carry and took wrong clock count");

    property p_mov_bit_c;
        take && instr.op == `CBBAE_OP_MOV_BIT_C |-> ##4 (done && bit_we);
    endproperty
    a_mov_bit_c: assert property (p_mov_bit_c)
        else $error("carry to bit not written at clock four");

    property p_jc;
        take && instr.op == `CBBAE_OP_JC |-> ##3 done;
    endproperty
    a_jc: assert property (p_jc)
        else $error("carry jump not three clocks");

    property p_jbc_keep;
        take && instr.op == `CBBAE_OP_JBC && !bit_in
            |-> ##1 !bit_we [*4] ##1 (done && !bit_we);
    endproperty
    a_jbc_keep: assert property (p_jbc_keep)
        else $error("bit cleared on untaken branch");

    property p_cjne_dir;
        take && instr.op == `CBBAE_OP_CJNE_ADIR |-> ##1 !done [*4] ##1 done;
    endproperty
    a_cjne_dir: assert property (p_cjne_dir)
        else $error("compare direct jump not five clocks");

    property p_call_push;
        take && page_call(instr.op)
            |-> ##4 (ram_we && ram_addr == $past(arch_in.stack_pointer, 4)
                     + 8'h01)
                ##1 (ram_we && ram_addr == $past(arch_in.stack_pointer, 5)
                     + 8'h02) ##1 done;
    endproperty
    a_call_push: assert property (p_call_push)
        else $error("call pushes out of order or place");

    property p_ajmp_page;
        take && page_jump(instr.op) |=> arch_out.pc[15:11] ==
            $past(arch_in.pc[15:11] + {4'h0, arch_in.pc[10:0] > 11'h7FD})
            && arch_out.pc[7:0] == $past(instr.b1);
    endproperty
    a_ajmp_page: assert property (p_ajmp_page)
        else $error("absolute jump left its block");

    property p_add_ov;
        take && instr.op == `CBBAE_OP_ADD_DIR
            |=> arch_out.signed_overflow_flag ==
                (($past(arch_in.acc[7]) == $past(operand[7])) &&
                 (arch_out.acc[7] != $past(arch_in.acc[7])));
    endproperty
    a_add_ov: assert property (p_add_ov)
        else $error("overflow flag wrong after add");

endmodule

// ===== cbbae_pkg.sv
// types for the bit, branch and add execution unit
package cbbae_pkg;

    typedef struct packed {
        logic [7:0] op;
        logic [7:0] b1;
        logic [7:0] b2;
    } cbbae_instr_t;

    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] data_pointer;
        logic [7:0]  stack_pointer;
        logic [7:0]  acc;
        logic        cy;
        logic        half_carry_flag;
        logic        signed_overflow_flag;
    } cbbae_arch_t;

    typedef struct packed {
        logic [2:0]  rem;
        cbbae_arch_t arch;
        logic        unknown;
        logic        call;
        logic [7:0]  sp_base;
        logic [15:0] ret;
        logic        bit_wr;
        logic        bit_val;
        logic [7:0]  bit_addr;
        logic        byte_wr;
        logic [7:0]  byte_val;
        logic [7:0]  byte_addr;
    } cbbae_state_t;

endpackage

// ===== testbench.sv
// self-checking bench for the bit, branch and add execution unit
`timescale 1ns/1ns
`include "cbbae_cfg.svh"
`define CHK(got, exp) \
    begin \
        n_tests = n_tests + 1; \
        if ((got) !== (exp)) \
        begin \
            fail_count = fail_count + 1; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end

module testbench import cbbae_pkg::*;;
    localparam int NOPS = 36;
    logic         clk;
    logic         resetn;
    logic         issue_valid;
    cbbae_instr_t instr;
    cbbae_arch_t  arch_in;
    logic [7:0]   operand;
    logic [7:0]   operand_addr;
    logic         bit_in;
    logic [15:0]  ret_addr_in;
    logic         ready;
    logic         done;
    logic         unknown_op;
    cbbae_arch_t  arch_out;
    logic         ram_we;
    logic [7:0]   ram_addr;
    logic [7:0]   ram_wdata;
    logic         bit_we;
    logic [7:0]   bit_addr;
    logic         bit_wdata;
    int           fail_count;
    int           n_tests;
    int           ncyc;
    int           bw_n;
    integer       seed;
    logic         bw_v;
    logic [7:0]   bw_a;
    logic [15:0]  ret_v;
    logic [7:0]   push_a[$];
    logic [7:0]   push_d[$];
    int           push_c[$];
    // fixed opcodes, pattern members after their own group, then page forms, one stray code
    logic [7:0] op_tab [NOPS] = '{8'h82, 8'hB0, 8'h7A, 8'hA0, 8'hA2, 8'h93,
        8'h40, 8'h50, 8'h20, 8'h30, 8'h10, 8'h03, 8'h22, 8'h33, 8'h02,
        8'h80, 8'h73, 8'h60, 8'h70, 8'hB5, 8'hB4, 8'hB6, 8'hBB, 8'hD5,
        8'hDA, 8'h25, 8'h24, 8'h27, 8'h2D, 8'h35, 8'h34, 8'h36, 8'h3F,
        8'h12, 8'h01, 8'hA5};
    int cyc_tab [NOPS] = '{3, 3, 3, 3, 3, 4, 3, 3, 4, 4, 5, 6, 4, 4, 4,
        3, 3, 3, 3, 5, 4, 5, 4, 5, 4, 1, 1, 1, 1, 1, 1, 1, 1, 6, 3, 1};
    logic [7:0] add_tab [8] = '{8'h28, 8'h25, 8'h26, 8'h24,
        8'h38, 8'h35, 8'h36, 8'h34};

    cbbae_exec i_cbbae_exec (
        .clk          (clk),
        .resetn       (resetn),
        .issue_valid  (issue_valid),
        .instr        (instr),
        .arch_in      (arch_in),
        .operand      (operand),
        .operand_addr (operand_addr),
        .bit_in       (bit_in),
        .ret_addr_in  (ret_addr_in),
        .ready        (ready),
        .done         (done),
        .unknown_op   (unknown_op),
        .arch_out     (arch_out),
        .ram_we       (ram_we),
        .ram_addr     (ram_addr),
        .ram_wdata    (ram_wdata),
        .bit_we       (bit_we),
        .bit_addr     (bit_addr),
        .bit_wdata    (bit_wdata)
    );

    initial clk = 1'b0;
    always #2 clk = ~clk;

    function automatic logic [15:0] sext(input logic [7:0] rel);
        return {{8{rel[7]}}, rel};
    endfunction

    task finish_test;
        if (fail_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // one instruction, logging pushes and bit writes until done
    task run(input cbbae_instr_t i, input cbbae_arch_t a,
             input logic [7:0] opd, input logic b);
        int k;
        push_a.delete();
        push_d.delete();
        push_c.delete();
        bw_n = 0;
        ret_v = $random(seed);
        @(posedge clk);
        issue_valid  <= 1'b1;
        instr        <= i;
        arch_in      <= a;
        operand      <= opd;
        bit_in       <= b;
        ret_addr_in  <= ret_v;
        operand_addr <= 8'(seed);
        @(posedge clk);
        issue_valid <= 1'b0;
        ncyc = 0;
        // first look is in cycle one, just after the take edge
        for (k = 1; k <= 20 && ncyc == 0; k++)
        begin
            #1;
            if (ram_we === 1'b1)
            begin
                push_a.push_back(ram_addr);
                push_d.push_back(ram_wdata);
                push_c.push_back(k);
            end
            if (bit_we === 1'b1)
            begin
                bw_n = bw_n + 1;
                bw_v = bit_wdata;
                bw_a = bit_addr;
            end
            if (done === 1'b1)
                ncyc = k;
            else
                @(posedge clk);
        end
        if (ncyc == 0)
        begin
            fail_count = fail_count + 1;
            finish_test();
        end
    endtask

    initial
    begin : main
        cbbae_instr_t i;
        cbbae_arch_t  a;
        logic [63:0]  r;
        logic [15:0]  ret;
        logic         tk;
        logic         c;
        int           j;
        int           sum;
        int           s;
        fail_count = 0;
        n_tests = 0;
        seed = 32'h2970_fb1c;
        resetn = 1'b0;
        issue_valid = 1'b0;
        instr = '0;
        arch_in = '0;
        operand = 8'h00;
        operand_addr = 8'h00;
        bit_in = 1'b0;
        ret_addr_in = 16'h0000;
        repeat (6) @(posedge clk);
        #1;
        `CHK({ready, done, ram_we, bit_we}, 4'b1000)
        `CHK(arch_out, 51'h0)
        @(posedge clk);
        resetn <= 1'b1;
        for (j = 0; j < NOPS; j++)
        begin
            r = {$random(seed), $random(seed)};
            a = r[$bits(cbbae_arch_t)-1:0];
            if (r[60])
                a.acc = 8'h00;
            i = {op_tab[j], r[63:48]};
            run(i, a, r[39:32], r[61]);
            `CHK(ncyc, cyc_tab[j])
            `CHK(unknown_op, i.op == 8'hA5)
            case (i.op)
                8'h82: c = a.cy & r[61];
                8'hB0: c = a.cy & ~r[61];
                8'h7A: c = a.cy | r[61];
                8'hA0: c = a.cy | ~r[61];
                8'hA2: c = r[61];
                8'h24, 8'h25, 8'h27, 8'h2D, 8'h34, 8'h35, 8'h36, 8'h3F:
                    c = (a.acc + ((i.op[3:0] == 4'h4) ? i.b1 : r[39:32]) +
                         (i.op[4] & a.cy)) > 255;
                8'hB5: c = a.acc < r[39:32];
                8'hB4: c = a.acc < i.b1;
                8'hB6, 8'hBB: c = r[39:32] < i.b1;
                default: c = a.cy;
            endcase
            `CHK(arch_out.cy, c)
            if (i.op == 8'h93)
                `CHK({bw_n[1:0], bw_v}, {2'd1, a.cy})
            if (i.op == 8'h22 || i.op == 8'h33)
                `CHK({arch_out.pc, arch_out.stack_pointer},
                     {ret_v, a.stack_pointer - 8'h02})
            if (i.op == 8'h73)
                `CHK(arch_out.pc, a.data_pointer + {8'h00, a.acc})
            if (i.op == 8'hD5 || i.op == 8'hDA)
                `CHK(push_d[0], r[39:32] - 8'h01)
            tk = (i.op == 8'h40) ? a.cy : (i.op == 8'h50) ? !a.cy :
                 (i.op == 8'h60) ? (a.acc == 8'h00) :
                 (i.op == 8'h70) ? (a.acc != 8'h00) : 1'b1;
            if (i.op inside {8'h40, 8'h50, 8'h60, 8'h70, 8'h80})
                `CHK(arch_out.pc,
                     a.pc + 16'h0002 + (tk ? sext(i.b1) : 16'h0))
        end
        for (j = 0; j < 40; j++)
        begin
            r = {$random(seed), $random(seed)};
            a = r[$bits(cbbae_arch_t)-1:0];
            i = {add_tab[r[2:0]], r[63:48]};
            if (i.op[3])
                i.op[2:0] = r[5:3];
            else if (i.op[1])
                i.op[0] = r[3];
            run(i, a, r[39:32], 1'b0);
            s = (i.op[3:0] == 4'h4) ? i.b1 : r[39:32];
            c = i.op[4] & a.cy;
            sum = a.acc + s + c;
            `CHK(ncyc, 1)
            `CHK(arch_out.acc, sum[7:0])
            `CHK(arch_out.cy, sum[8])
            `CHK(arch_out.half_carry_flag,
                 (a.acc[3:0] + s[3:0] + c) > 15)
            `CHK(arch_out.signed_overflow_flag,
                 sum[8] ^ ((a.acc[6:0] + s[6:0] + c) > 127))
            `CHK(arch_out.pc,
                 a.pc + ((i.op[3:1] == 3'b010) ? 16'h0002 : 16'h0001))
        end
        // page forms, pc near a 2K edge so the increment may cross it
        for (j = 0; j < 16; j++)
        begin
            r = {$random(seed), $random(seed)};
            a = r[$bits(cbbae_arch_t)-1:0];
            a.pc = {r[63:59], 11'h7FE} - {15'h0, r[58]};
            i = {j[2:0], j[3] ? 5'b10010 : 5'b00001, r[47:32]};
            ret = a.pc + 16'h0002;
            run(i, a, 8'h00, 1'b0);
            `CHK(arch_out.pc, {ret[15:11], j[2:0], i.b1})
            `CHK({arch_out.cy, arch_out.half_carry_flag,
                  arch_out.signed_overflow_flag},
                 {a.cy, a.half_carry_flag, a.signed_overflow_flag})
            if (j[3])
            begin
                `CHK(ncyc, 6)
                `CHK(arch_out.stack_pointer, a.stack_pointer + 8'h02)
                `CHK({push_a[0], push_d[0], push_a[1], push_d[1]},
                     {a.stack_pointer + 8'h01, ret[7:0],
                      a.stack_pointer + 8'h02, ret[15:8]})
                `CHK({push_c[0], push_c[1], push_c.size()},
                     {32'd4, 32'd5, 32'd2})
            end
            else
                `CHK({ncyc, push_c.size()}, {32'd3, 32'd0})
        end
        for (j = 0; j < 6; j++)
        begin
            r = {$random(seed), $random(seed)};
            a = r[$bits(cbbae_arch_t)-1:0];
            i = {(j < 2) ? 8'h20 : (j < 4) ? 8'h30 : 8'h10, r[47:32]};
            run(i, a, 8'h00, j[0]);
            tk = (i.op == 8'h30) ? !j[0] : j[0];
            `CHK(ncyc, (i.op == 8'h10) ? 5 : 4)
            `CHK(arch_out.pc, a.pc + 16'h0003 + (tk ? sext(i.b2) : 16'h0))
            if (i.op == 8'h10)
                `CHK({bw_n[1:0], bw_v, bw_a},
                     j[0] ? {2'd1, 1'b0, i.b1} : {2'd0, bw_v, bw_a})
        end
        finish_test();
    end
endmodule
